/* File: design/pulse_train.sv */
// led pulse train generator for one time slot of one internal sample
`include "readout_defs.svh"
`default_nettype none
module pulse_train (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] offset_us,
	input wire logic [4:0] width_us,
	input wire logic [7:0] period_us,
	input wire logic [7:0] pulse_count,
	output logic led_on_r,
	output logic take_r,
	output logic done_r
);
	readout_pkg::pulse_phase_t phase_r;
	logic [15:0] cnt_r;
	logic [7:0] sent_r;
	logic [15:0] offset_cyc;
	logic [15:0] width_cyc;
	logic [15:0] period_cyc;

	// phase lengths in cycles; a zero width still gives one microsecond of light
	assign offset_cyc = 16'(offset_us) * 16'(`CYC_PER_US);
	assign width_cyc = ((width_us == 5'h00) ? 16'h0001 : 16'(width_us)) * 16'(`CYC_PER_US);
	assign period_cyc = 16'(period_us) * 16'(`CYC_PER_US);

	// the count runs from the start of each pulse so the period is start to start
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= readout_pkg::PH_IDLE;
			cnt_r <= 16'h0000;
			sent_r <= 8'h00;
			led_on_r <= 1'b0;
			take_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			take_r <= 1'b0;
			done_r <= 1'b0;
			case (phase_r)
				readout_pkg::PH_IDLE: begin
					cnt_r <= 16'h0000;
					sent_r <= 8'h00;
					if (start) begin
						if (pulse_count == 8'h00) begin
							done_r <= 1'b1;
						end else begin
							phase_r <= readout_pkg::PH_OFFSET;
						end
					end
				end
				readout_pkg::PH_OFFSET: begin
					if (cnt_r + 16'h0001 >= offset_cyc) begin
						cnt_r <= 16'h0000;
						led_on_r <= 1'b1;
						phase_r <= readout_pkg::PH_PULSE;
					end else begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				readout_pkg::PH_PULSE: begin
					cnt_r <= cnt_r + 16'h0001;
					if (cnt_r + 16'h0001 >= width_cyc) begin
						led_on_r <= 1'b0;
						take_r <= 1'b1;
						sent_r <= sent_r + 8'h01;
						if (sent_r + 8'h01 == pulse_count) begin
							done_r <= 1'b1;
							phase_r <= readout_pkg::PH_IDLE;
						end else begin
							phase_r <= readout_pkg::PH_GAP;
						end
					end
				end
				readout_pkg::PH_GAP: begin
					if (cnt_r + 16'h0001 >= period_cyc) begin
						cnt_r <= 16'h0000;
						led_on_r <= 1'b1;
						phase_r <= readout_pkg::PH_PULSE;
					end else begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				default: begin
					phase_r <= readout_pkg::PH_IDLE;
					led_on_r <= 1'b0;
				end
			endcase
		end
	end
endmodule // pulse_train
`default_nettype wire

/* File: design/readout_ctrl.sv */
// sample timing, pulse repetition, averaging and diagnostic path control
//
// Contract
// [RULE1] each internal sample emits the slot's pulse count of led pulses
// [RULE2] internal samples per slot are combined as set by the averaging fields
// [RULE3] pulses per output word equal pulse count times averaged samples
// [RULE4] output word rate is sample rate divided by samples combined
// [RULE5] host raises sample frequency by the averaging factor to hold output rate
// [RULE6] host keeps pulse count at sixteen or less for best efficiency
// [RULE7] each enabled slot drives its chosen emitter for the width, once per pulse
// [RULE8] host enters diagnostic mode with 0xB065 and zeroed converter offsets
// [RULE9] diagnostic mode feeds amplifier straight to converter, background light only
// [RULE10] diagnostic values fall as light rises; relative measure only
// [RULE11] host writes program state to mode register before configuring
// [RULE12] host restores analog and offset registers when leaving diagnostic mode
`include "readout_defs.svh"
`default_nettype none
module readout_ctrl (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata_r,
	input wire logic [13:0] conv_data,
	output logic led_first_r,
	output logic led_second_r,
	output logic amp_bypass_r,
	output logic [26:0] data_word_r,
	output logic data_valid_r,
	output logic data_slot_r
);
	logic [15:0] op_mode_r;
	logic [15:0] slot_enable_r;
	logic [15:0] sample_freq_r;
	logic [15:0] led_select_r;
	logic [15:0] avg_count_r;
	logic [15:0] slot_a_timing_r;
	logic [15:0] slot_a_pulse_r;
	logic [15:0] slot_b_timing_r;
	logic [15:0] slot_b_pulse_r;
	logic [15:0] analog_path_r;
	logic [15:0] offset_r [`OFFSET_COUNT];
	logic [15:0] reg_rdata_nxt;
	logic running;
	logic direct_mode;
	logic [15:0] tick_cnt_r;
	logic [15:0] fs_cnt_r;
	logic sample_tick_r;
	readout_pkg::seq_state_t seq_r;
	logic slot_sel_r;
	logic start_r;
	logic led_on;
	logic take;
	logic done;
	logic [15:0] cur_timing;
	logic [15:0] cur_pulse;
	logic [13:0] cur_offset;
	logic [13:0] sample_val;
	logic [4:0] off_idx;

	assign running = (op_mode_r == `MODE_RUN);
	assign direct_mode = (analog_path_r == `DIRECT_AMP_CONV_CODE);

	// register writes other than the mode register only take effect in the program state
	// [RULE11] program state gate
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_mode_r <= `RST_OP_MODE;
			slot_enable_r <= `RST_ZERO;
			sample_freq_r <= `RST_SAMPLE_FREQ;
			led_select_r <= `RST_ZERO;
			avg_count_r <= `RST_ZERO;
			slot_a_timing_r <= `RST_ZERO;
			slot_a_pulse_r <= `RST_ZERO;
			slot_b_timing_r <= `RST_ZERO;
			slot_b_pulse_r <= `RST_ZERO;
			analog_path_r <= `RST_ZERO;
		end else if (reg_wr) begin
			if (reg_addr == `REG_OP_MODE) begin
				op_mode_r <= reg_wdata;
			end else if (op_mode_r == `MODE_PROGRAM) begin
				if (reg_addr == `REG_SLOT_ENABLE) begin
					slot_enable_r <= reg_wdata;
				end else if (reg_addr == `REG_SAMPLE_FREQ) begin
					sample_freq_r <= reg_wdata;
				end else if (reg_addr == `REG_LED_SELECT) begin
					led_select_r <= reg_wdata;
				end else if (reg_addr == `REG_AVG_COUNT) begin
					avg_count_r <= reg_wdata;
				end else if (reg_addr == `REG_SLOT_A_TIMING) begin
					slot_a_timing_r <= reg_wdata;
				end else if (reg_addr == `REG_SLOT_A_PULSE) begin
					slot_a_pulse_r <= reg_wdata;
				end else if (reg_addr == `REG_SLOT_B_TIMING) begin
					slot_b_timing_r <= reg_wdata;
				end else if (reg_addr == `REG_SLOT_B_PULSE) begin
					slot_b_pulse_r <= reg_wdata;
				end else if (reg_addr == `REG_ANALOG_PATH) begin
					analog_path_r <= reg_wdata;
				end
			end
		end
	end

	// converter offset registers, one per channel per slot
	// [RULE8] offsets writable for diagnostic entry
	generate
		for (genvar i = 0; i < `OFFSET_COUNT; i++) begin : g_offset
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					offset_r[i] <= `RST_ZERO;
				end else if (reg_wr && op_mode_r == `MODE_PROGRAM
					&& reg_addr == `REG_OFFSET_FIRST + 8'(i)) begin
					offset_r[i] <= reg_wdata;
				end
			end
		end
	endgenerate

	// read mux; unmapped addresses read as zero
	assign off_idx = 5'(reg_addr - `REG_OFFSET_FIRST);
	always_comb begin
		reg_rdata_nxt = 16'h0000;
		if (reg_addr == `REG_STATUS) begin
			reg_rdata_nxt = {11'h000, direct_mode, slot_sel_r, seq_r};
		end else if (reg_addr == `REG_OP_MODE) begin
			reg_rdata_nxt = op_mode_r;
		end else if (reg_addr == `REG_SLOT_ENABLE) begin
			reg_rdata_nxt = slot_enable_r;
		end else if (reg_addr == `REG_SAMPLE_FREQ) begin
			reg_rdata_nxt = sample_freq_r;
		end else if (reg_addr == `REG_LED_SELECT) begin
			reg_rdata_nxt = led_select_r;
		end else if (reg_addr == `REG_AVG_COUNT) begin
			reg_rdata_nxt = avg_count_r;
		end else if (reg_addr >= `REG_OFFSET_FIRST && reg_addr <= `REG_OFFSET_LAST) begin
			reg_rdata_nxt = offset_r[off_idx[3:0]];
		end else if (reg_addr == `REG_SLOT_A_TIMING) begin
			reg_rdata_nxt = slot_a_timing_r;
		end else if (reg_addr == `REG_SLOT_A_PULSE) begin
			reg_rdata_nxt = slot_a_pulse_r;
		end else if (reg_addr == `REG_SLOT_B_TIMING) begin
			reg_rdata_nxt = slot_b_timing_r;
		end else if (reg_addr == `REG_SLOT_B_PULSE) begin
			reg_rdata_nxt = slot_b_pulse_r;
		end else if (reg_addr == `REG_ANALOG_PATH) begin
			reg_rdata_nxt = analog_path_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata_r <= reg_rdata_nxt;
		end
	end

	// sample clock: one internal sample every sample_freq base ticks
	// a zero divisor is treated as one so the timer never stalls
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 16'h0000;
			fs_cnt_r <= 16'h0000;
			sample_tick_r <= 1'b0;
		end else begin
			sample_tick_r <= 1'b0;
			if (!running) begin
				tick_cnt_r <= 16'h0000;
				fs_cnt_r <= 16'h0000;
			end else if (tick_cnt_r == 16'(`FS_TICK_CYCLES - 1)) begin
				tick_cnt_r <= 16'h0000;
				if (fs_cnt_r + 16'h0001 >= sample_freq_r) begin
					fs_cnt_r <= 16'h0000;
					sample_tick_r <= 1'b1;
				end else begin
					fs_cnt_r <= fs_cnt_r + 16'h0001;
				end
			end else begin
				tick_cnt_r <= tick_cnt_r + 16'h0001;
			end
		end
	end

	// slot sequencer: slot A then slot B within each internal sample
	// a tick that lands while a sample is still running is dropped
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_r <= readout_pkg::SEQ_IDLE;
			slot_sel_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			case (seq_r)
				readout_pkg::SEQ_IDLE: begin
					if (sample_tick_r && slot_enable_r[`SLOT_A_EN_BIT]) begin
						seq_r <= readout_pkg::SEQ_SLOT_A;
						slot_sel_r <= 1'b0;
						start_r <= 1'b1;
					end else if (sample_tick_r && slot_enable_r[`SLOT_B_EN_BIT]) begin
						seq_r <= readout_pkg::SEQ_SLOT_B;
						slot_sel_r <= 1'b1;
						start_r <= 1'b1;
					end
				end
				readout_pkg::SEQ_SLOT_A: begin
					if (done && slot_enable_r[`SLOT_B_EN_BIT]) begin
						seq_r <= readout_pkg::SEQ_SLOT_B;
						slot_sel_r <= 1'b1;
						start_r <= 1'b1;
					end else if (done) begin
						seq_r <= readout_pkg::SEQ_IDLE;
					end
				end
				readout_pkg::SEQ_SLOT_B: begin
					if (done) begin
						seq_r <= readout_pkg::SEQ_IDLE;
					end
				end
				default: begin
					seq_r <= readout_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	// parameters of the slot being pulsed
	assign cur_timing = slot_sel_r ? slot_b_timing_r : slot_a_timing_r;
	assign cur_pulse = slot_sel_r ? slot_b_pulse_r : slot_a_pulse_r;
	assign cur_offset = slot_sel_r ? offset_r[`OFFSET_IDX_B][13:0]
		: offset_r[`OFFSET_IDX_A][13:0];

	// [RULE1] pulses per sample
	pulse_train u_pulse_train (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(start_r),
		.offset_us(cur_timing[`PULSE_OFFSET_MSB:`PULSE_OFFSET_LSB]),
		.width_us(cur_timing[`PULSE_WIDTH_MSB:`PULSE_WIDTH_LSB]),
		.period_us(cur_pulse[`PULSE_PERIOD_MSB:`PULSE_PERIOD_LSB]),
		.pulse_count(cur_pulse[`PULSE_COUNT_MSB:`PULSE_COUNT_LSB]),
		.led_on_r(led_on),
		.take_r(take),
		.done_r(done)
	);

	// emitter steering; the diagnostic path keeps both emitters dark
	// [RULE7] drive selected emitter
	// [RULE9] no led in diagnostic mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_first_r <= 1'b0;
			led_second_r <= 1'b0;
			amp_bypass_r <= 1'b0;
		end else begin
			amp_bypass_r <= direct_mode;
			led_first_r <= led_on && !direct_mode
				&& !led_select_r[slot_sel_r ? `LED_SEL_B_BIT : `LED_SEL_A_BIT];
			led_second_r <= led_on && !direct_mode
				&& led_select_r[slot_sel_r ? `LED_SEL_B_BIT : `LED_SEL_A_BIT];
		end
	end

	// normal path removes the offset and clamps at zero; the direct path passes raw
	// converter codes, which drop as light rises since the amplifier inverts
	// [RULE10] raw inverted codes
	assign sample_val = direct_mode ? conv_data
		: ((conv_data > cur_offset) ? conv_data - cur_offset : 14'h0000);

	// per-slot burst sum and inter-sample averaging; the sum is not divided so
	// no resolution is lost, at the cost of a word that grows with the count
	logic [26:0] sum_r [2];
	logic [7:0] samples_r [2];
	logic [1:0] emit;
	generate
		for (genvar s = 0; s < 2; s++) begin : g_slot
			logic [2:0] avg_sel;
			logic [7:0] avg_target;
			assign avg_sel = (s == 0) ? avg_count_r[`AVG_A_MSB:`AVG_A_LSB]
				: avg_count_r[`AVG_B_MSB:`AVG_B_LSB];
			// [RULE2] samples combined per word
			assign avg_target = 8'h01 << avg_sel;
			// [RULE4] one word per target samples
			assign emit[s] = running && done && (slot_sel_r == 1'(s))
				&& (samples_r[s] + 8'h01 >= avg_target);
			// [RULE3] pulses times samples summed
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					sum_r[s] <= 27'h0000000;
					samples_r[s] <= 8'h00;
				end else if (!running) begin
					sum_r[s] <= 27'h0000000;
					samples_r[s] <= 8'h00;
				end else if (emit[s]) begin
					sum_r[s] <= 27'h0000000;
					samples_r[s] <= 8'h00;
				end else if (slot_sel_r == 1'(s)) begin
					// the last pulse's take lands with done, so both are applied
					if (done) begin
						samples_r[s] <= samples_r[s] + 8'h01;
					end
					if (take) begin
						sum_r[s] <= sum_r[s] + 27'(sample_val);
					end
				end
			end
		end
	endgenerate

	// output word, presented for one cycle when a slot's average completes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_word_r <= 27'h0000000;
			data_valid_r <= 1'b0;
			data_slot_r <= 1'b0;
		end else begin
			data_valid_r <= |emit;
			if (|emit) begin
				// fold in the final pulse, whose take coincides with the emit
				data_word_r <= sum_r[slot_sel_r] + (take ? 27'(sample_val) : 27'h0000000);
				data_slot_r <= slot_sel_r;
			end
		end
	end
endmodule // readout_ctrl
`default_nettype wire

/* File: pkg/readout_defs.svh */
// register offsets, field positions, reset values and timing counts of the readout block
`ifndef READOUT_DEFS_SVH
`define READOUT_DEFS_SVH

// register map
`define REG_STATUS 8'h00
`define REG_OP_MODE 8'h10
`define REG_SLOT_ENABLE 8'h11
`define REG_SAMPLE_FREQ 8'h12
`define REG_LED_SELECT 8'h14
`define REG_AVG_COUNT 8'h15
`define REG_OFFSET_FIRST 8'h18
`define REG_OFFSET_LAST 8'h21
`define REG_SLOT_A_TIMING 8'h30
`define REG_SLOT_A_PULSE 8'h31
`define REG_SLOT_B_TIMING 8'h35
`define REG_SLOT_B_PULSE 8'h36
`define REG_ANALOG_PATH 8'h45

// offset registers used by each slot (third channel of each slot)
`define OFFSET_IDX_A 4'h2
`define OFFSET_IDX_B 4'h8
`define OFFSET_COUNT 10

// field positions
`define PULSE_COUNT_MSB 15
`define PULSE_COUNT_LSB 8
`define PULSE_PERIOD_MSB 7
`define PULSE_PERIOD_LSB 0
`define PULSE_WIDTH_MSB 12
`define PULSE_WIDTH_LSB 8
`define PULSE_OFFSET_MSB 7
`define PULSE_OFFSET_LSB 0
`define AVG_A_MSB 6
`define AVG_A_LSB 4
`define AVG_B_MSB 10
`define AVG_B_LSB 8
`define SLOT_A_EN_BIT 0
`define SLOT_B_EN_BIT 2
`define LED_SEL_A_BIT 8
`define LED_SEL_B_BIT 10

// values and reset values
`define MODE_PROGRAM 16'h0001
`define MODE_RUN 16'h0002
`define DIRECT_AMP_CONV_CODE 16'hB065
`define RST_OP_MODE 16'h0001
`define RST_SAMPLE_FREQ 16'h0008
`define RST_ZERO 16'h0000

// timing: clock period, one microsecond, base tick of the sample frequency divider
`define CLK_PERIOD_NS 100
`define ONE_US_NS 1000
`define CYC_PER_US (`ONE_US_NS / `CLK_PERIOD_NS)
`define FS_TICK_US 125
`define FS_TICK_CYCLES (`FS_TICK_US * `CYC_PER_US)

`endif

/* File: pkg/readout_pkg.sv */
// types shared by the readout control block
`default_nettype none
package readout_pkg;
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_SLOT_A = 3'b010,
		SEQ_SLOT_B = 3'b100
	} seq_state_t;

	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_OFFSET = 4'b0010,
		PH_PULSE = 4'b0100,
		PH_GAP = 4'b1000
	} pulse_phase_t;
endpackage
`default_nettype wire

/* File: tb/host_model.sv */
// host processor model: register access and the front end light level
`include "readout_defs.svh"
`default_nettype none
module host_model (
	input wire logic sys_clk,
	input wire logic [15:0] reg_rdata_r,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [13:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// bus idle at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		conv_data = 14'h0000;
	end
	// held through the taking edge, then scrambled so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk);
		#10;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// read data is taken one cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#10;
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(posedge sys_clk);
		#10;
		v = reg_rdata_r;
	endtask
	// full configuration pass; the light level only changes while sampling is stopped
	task automatic setup(input logic [15:0] fs, avg, pa, pb, input logic diag,
		input logic [13:0] ofs, cv);
		wr(`REG_OP_MODE, `MODE_PROGRAM);
		conv_data = cv;
		wr(`REG_SLOT_ENABLE, 16'h0005);
		wr(`REG_LED_SELECT, 16'h0100);
		wr(`REG_SLOT_A_TIMING, 16'h0102);
		wr(`REG_SLOT_B_TIMING, 16'h0102);
		wr(`REG_SAMPLE_FREQ, fs);
		wr(`REG_AVG_COUNT, avg);
		wr(`REG_SLOT_A_PULSE, pa);
		wr(`REG_SLOT_B_PULSE, pb);
		for (int i = 8'h18; i <= 8'h21; i++) wr(8'(i), diag ? 16'h0000 : {2'b00, ofs});
		wr(`REG_ANALOG_PATH, diag ? `DIRECT_AMP_CONV_CODE : 16'h0000);
		wr(`REG_OP_MODE, `MODE_RUN);
	endtask
endmodule // host_model
`default_nettype wire

/* File: tb/readout_checker.sv */
// port-level checks for the readout control block
`include "readout_defs.svh"
`default_nettype none
module readout_checker (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata_r,
	input wire logic [13:0] conv_data,
	input wire logic led_first_r,
	input wire logic led_second_r,
	input wire logic amp_bypass_r,
	input wire logic [26:0] data_word_r,
	input wire logic data_valid_r,
	input wire logic data_slot_r
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prog_r, diag_r;
	logic [10:0] quiet_r;
	logic [15:0] gap_r;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// shadow of the mode register; only program state lets other writes in
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) prog_r <= 1'b1;
		else if (reg_wr && reg_addr == `REG_OP_MODE) prog_r <= reg_wdata == `MODE_PROGRAM;
	end
	// shadow of the direct path code, refused outside program state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) diag_r <= 1'b0;
		else if (reg_wr && prog_r && reg_addr == `REG_ANALOG_PATH)
			diag_r <= reg_wdata == `DIRECT_AMP_CONV_CODE;
	end
	// cycles in program state, saturating so a long idle never wraps
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) quiet_r <= 11'h000;
		else if (!prog_r) quiet_r <= 11'h000;
		else if (quiet_r != 11'h7FF) quiet_r <= quiet_r + 11'h001;
	end
	// cycles since the last slot A word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) gap_r <= 16'hFFFF;
		else if (data_valid_r && !data_slot_r) gap_r <= 16'h0000;
		else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
	end
	chk_single_emitter: assert property (!(led_first_r && led_second_r))
		else $error("both emitters on");
	chk_bypass_dark: assert property (amp_bypass_r |-> !led_first_r && !led_second_r)
		else $error("emitter on in direct path");
	chk_bypass_cause: assert property ($rose(amp_bypass_r) |-> diag_r)
		else $error("direct path without its code");
	chk_bypass_leave: assert property ($fell(diag_r) |-> ##[0:2] !amp_bypass_r)
		else $error("direct path kept");
	chk_valid_single: assert property (data_valid_r |=> !data_valid_r)
		else $error("word strobe too long");
	chk_word_hold: assert property (!data_valid_r |-> $stable(data_word_r) && $stable(data_slot_r))
		else $error("word changed without strobe");
	chk_quiet_program: assert property (quiet_r == 11'h7FF |-> !led_first_r && !led_second_r && !data_valid_r)
		else $error("activity in program state");
	chk_rate_floor: assert property (data_valid_r && !data_slot_r |-> gap_r >= `FS_TICK_CYCLES - 1)
		else $error("slot A words too close");
	cov_word_a: cover property (data_valid_r && !data_slot_r);
	cov_word_b: cover property (data_valid_r && data_slot_r);
	cov_direct: cover property (amp_bypass_r && data_valid_r);
endmodule // readout_checker
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the readout control block
`include "readout_defs.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata_r, rv;
	logic reg_wr, reg_rd, led_first_r, led_second_r, amp_bypass_r, data_valid_r, data_slot_r;
	logic [13:0] conv_data;
	logic [26:0] data_word_r;
	logic [26:0] q[2][$];
	logic p1 = 1'b0;
	logic p2 = 1'b0;
	logic [7:0] ra[5] = '{8'h10, 8'h12, 8'h15, 8'h7F, 8'h00};
	logic [15:0] re[5] = '{16'h0001, 16'h0008, 16'h0000, 16'h0000, 16'h0001};
	int bad_count, samples_checked, cyc, s, na, nb;
	int pl[2], exp_pl[2], exp_gap[2], last[2];
	always #50 sys_clk = ~sys_clk;
	readout_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.conv_data(conv_data), .led_first_r(led_first_r), .led_second_r(led_second_r),
		.amp_bypass_r(amp_bypass_r), .data_word_r(data_word_r),
		.data_valid_r(data_valid_r), .data_slot_r(data_slot_r));
	host_model i_host (.sys_clk(sys_clk), .reg_rdata_r(reg_rdata_r), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .conv_data(conv_data));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t ns: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watcher: counts pulses per emitter and pairs each word with the oldest note
	always @(posedge sys_clk) begin
		#1;
		cyc++;
		if (led_second_r === 1'b1 && !p2) pl[0]++;
		if (led_first_r === 1'b1 && !p1) pl[1]++;
		p1 = led_first_r === 1'b1;
		p2 = led_second_r === 1'b1;
		if (data_valid_r === 1'b1) begin
			s = data_slot_r === 1'b1;
			if (q[s].size() == 0) check(1, 0);
			else check(data_word_r, q[s].pop_front());
			check(pl[s], exp_pl[s]);
			if (last[s] != 0) check(cyc - last[s], exp_gap[s]);
			last[s] = cyc;
			pl[s] = 0;
		end
		// hang guard, well beyond the longest expected run
		if (cyc == 60000) begin
			bad_count++;
			summarize();
		end
	end
	// one setting: notes the expected words, then waits until all have come
	task automatic run(input logic [15:0] fs, input int na, nb, ca, cb, wa, input logic diag,
		input logic [13:0] ofs, cv);
		int v;
		v = diag ? cv : (cv > ofs ? cv - ofs : 0);
		pl = '{0, 0};
		last = '{0, 0};
		exp_pl = '{diag ? 0 : ca << na, diag ? 0 : cb << nb};
		exp_gap = '{`FS_TICK_CYCLES * fs << na, `FS_TICK_CYCLES * fs << nb};
		for (int i = 0; i < wa; i++) q[0].push_back(27'((ca << na) * v));
		for (int i = 0; i < (wa << na) >> nb; i++) q[1].push_back(27'((cb << nb) * v));
		i_host.setup(fs, 16'((nb << 8) | (na << 4)), 16'((ca << 8) | 3), 16'((cb << 8) | 3),
			diag, ofs, cv);
		while (q[0].size() + q[1].size() != 0) @(posedge sys_clk);
		check(amp_bypass_r, diag);
		$display("test done: rate %0d, averaging %0d/%0d, direct %0d", fs, na, nb, diag);
	endtask
	initial begin
		void'($urandom(32'h8937));
		repeat (4) @(posedge sys_clk);
		#10;
		rst_n = 1'b1;
		// defaults and an unmapped place, then a long idle in program state
		foreach (ra[i]) begin
			i_host.rd(ra[i], rv);
			check(rv, re[i]);
		end
		repeat (2100) @(posedge sys_clk);
		$display("test done: register defaults");
		run(16'h0002, 1, 0, 8, 3, 2, 1'b0, 14'h0100, 14'($urandom));
		// writes outside program state are refused
		i_host.wr(`REG_AVG_COUNT, 16'h0770);
		i_host.rd(`REG_AVG_COUNT, rv);
		check(rv, 16'h0010);
		run(16'h0001, 0, 0, 4, 2, 2, 1'b1, 14'h0000, 14'($urandom));
		for (int k = 0; k < 3; k++) begin
			na = $urandom % 3;
			nb = $urandom % (na + 1);
			run(16'h0001, na, nb, 1 + $urandom % 16, 1 + $urandom % 16, 1, 1'b0,
				14'($urandom % 4096), 14'($urandom));
		end
		summarize();
	end
endmodule // tb_top
bind readout_ctrl readout_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_r(reg_rdata_r), .conv_data(conv_data), .led_first_r(led_first_r),
	.led_second_r(led_second_r), .amp_bypass_r(amp_bypass_r), .data_word_r(data_word_r),
	.data_valid_r(data_valid_r), .data_slot_r(data_slot_r));
`default_nettype wire
